//--- common/accum_snap_map.vh
`ifndef ACCUM_SNAP_MAP_VH
`define ACCUM_SNAP_MAP_VH

// Register offsets
`define OFS_ACCUM_SOURCE_PROG 8'h25
`define OFS_ACCUM_SOURCE_ACTIVE 8'h4A
`define OFS_ACCUM_SOURCE_LATCHED 8'h4B
`define OFS_PRODUCT_IDENTIFIER 8'hFD
`define OFS_MAKER_IDENTIFIER 8'hFE
`define OFS_DIE_REVISION 8'hFF

// Channel field positions (low bit of each two-bit field)
`define POS_CH1_ACCUM_SOURCE 6
`define POS_CH2_ACCUM_SOURCE 4
`define POS_CH3_ACCUM_SOURCE 2
`define POS_CH4_ACCUM_SOURCE 0

// Source encodings
`define SRC_POWER_PRODUCT 2'h0
`define SRC_SENSE_VOLTAGE 2'h1
`define SRC_BUS_VOLTAGE 2'h2
`define SRC_RESERVED 2'h3

// Reset values
`define RST_ACCUM_SOURCE 8'h00

// Identification codes (arbitrary neutral values)
`define ID_PRODUCT_CODE 8'hA1
`define ID_MAKER_CODE 8'hB2
`define ID_DIE_REVISION_CODE 8'h01

// Result validity delay after a refresh
`define RESULT_VALID_TIME_NS 1000000
`define CLK_PERIOD_NS 8
`define RESULT_VALID_CYCLES ((`RESULT_VALID_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- rtl/accum_config_snapshot_and_id_regs.v
`include "accum_snap_map.vh"
`timescale 1ns/10ps
`default_nettype none

module accum_config_snapshot_and_id_regs #(
  parameter [31:0] VALID_CYCLES = `RESULT_VALID_CYCLES
) (
  input wire clk_sys,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire refresh,
  input wire refresh_volt,
  input wire refresh_general,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  output reg [7:0] active_source,
  output reg snapshot_valid
);

  ////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam integer NUM_CHANNELS = 4;
  localparam integer FIELD_BITS = 2;

  // Register selector codes
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_PROG = 3'h1;
  localparam [2:0] SEL_ACTIVE = 3'h2;
  localparam [2:0] SEL_LATCHED = 3'h3;
  localparam [2:0] SEL_PRODUCT = 3'h4;
  localparam [2:0] SEL_MAKER = 3'h5;
  localparam [2:0] SEL_REVISION = 3'h6;

  // Validity timer states
  localparam [1:0] ST_READY = 2'h0;
  localparam [1:0] ST_SETTLE = 2'h1;

  // Timer constants
  localparam [31:0] COUNT_ZERO = 32'h00000000;
  localparam [31:0] COUNT_ONE = 32'h00000001;

  ////////////////////////////////////////////////////////////////////////
  // Map a register offset to a selector code
  function [2:0] decode_addr;
    input [7:0] addr;
    begin
      case (addr)
        `OFS_ACCUM_SOURCE_PROG: begin
          decode_addr = SEL_PROG;
        end
        `OFS_ACCUM_SOURCE_ACTIVE: begin
          decode_addr = SEL_ACTIVE;
        end
        `OFS_ACCUM_SOURCE_LATCHED: begin
          decode_addr = SEL_LATCHED;
        end
        `OFS_PRODUCT_IDENTIFIER: begin
          decode_addr = SEL_PRODUCT;
        end
        `OFS_MAKER_IDENTIFIER: begin
          decode_addr = SEL_MAKER;
        end
        `OFS_DIE_REVISION: begin
          decode_addr = SEL_REVISION;
        end
        default: begin
          decode_addr = SEL_NONE;
        end
      endcase
    end
  endfunction

  // Reserved code reads back as zero
  function [1:0] clean_field;
    input [1:0] raw;
    begin
      case (raw)
        `SRC_POWER_PRODUCT: begin
          clean_field = `SRC_POWER_PRODUCT;
        end
        `SRC_SENSE_VOLTAGE: begin
          clean_field = `SRC_SENSE_VOLTAGE;
        end
        `SRC_BUS_VOLTAGE: begin
          clean_field = `SRC_BUS_VOLTAGE;
        end
        default: begin
          clean_field = `SRC_POWER_PRODUCT;
        end
      endcase
    end
  endfunction

  // Low bit of a channel's field, channels numbered 1 to 4
  function integer field_pos;
    input integer chan;
    begin
      case (chan)
        32'h00000001: begin
          field_pos = `POS_CH1_ACCUM_SOURCE;
        end
        32'h00000002: begin
          field_pos = `POS_CH2_ACCUM_SOURCE;
        end
        32'h00000003: begin
          field_pos = `POS_CH3_ACCUM_SOURCE;
        end
        32'h00000004: begin
          field_pos = `POS_CH4_ACCUM_SOURCE;
        end
        default: begin
          field_pos = 32'h00000000;
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  reg [7:0] prog_source;
  reg [7:0] latched_source;
  reg [31:0] valid_count;
  reg [1:0] timer_state;
  reg [1:0] next_timer_state;
  reg [31:0] next_valid_count;
  reg next_snapshot_valid;
  reg [7:0] next_rdata;
  wire [2:0] access_sel;
  wire any_refresh;
  wire prog_write;
  wire [7:0] prog_clean;
  wire [7:0] active_clean;
  wire [7:0] latched_clean;

  assign any_refresh = refresh | refresh_volt | refresh_general;
  assign access_sel = decode_addr(reg_addr);
  assign prog_write = reg_wr & (access_sel == SEL_PROG);

  ////////////////////////////////////////////////////////////////////////
  // Programmed copy, changed by host writes only
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      prog_source <= `RST_ACCUM_SOURCE;
    end else if (prog_write) begin
      prog_source <= reg_wdata;
    end
  end

  // Active copy, loaded from the programmed copy on refresh
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      active_source <= `RST_ACCUM_SOURCE;
    end else if (any_refresh) begin
      active_source <= prog_source;
    end
  end

  // Latched copy keeps what was active before the refresh
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      latched_source <= `RST_ACCUM_SOURCE;
    end else if (any_refresh) begin
      latched_source <= active_source;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-channel read images with the reserved code cleared
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch = ch + 1) begin : g_clean
      localparam integer LOW = field_pos(NUM_CHANNELS - ch);
      wire [1:0] prog_raw;
      wire [1:0] active_raw;
      wire [1:0] latched_raw;
      assign prog_raw = prog_source[LOW +: FIELD_BITS];
      assign active_raw = active_source[LOW +: FIELD_BITS];
      assign latched_raw = latched_source[LOW +: FIELD_BITS];
      assign prog_clean[LOW +: FIELD_BITS] = clean_field(prog_raw);
      assign active_clean[LOW +: FIELD_BITS] = clean_field(active_raw);
      assign latched_clean[LOW +: FIELD_BITS] = clean_field(latched_raw);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Validity timer; a new refresh restarts the wait
  always @* begin
    next_timer_state = timer_state;
    next_valid_count = valid_count;
    next_snapshot_valid = snapshot_valid;
    case (timer_state)
      ST_READY: begin
        if (any_refresh) begin
          next_timer_state = ST_SETTLE;
          next_valid_count = VALID_CYCLES;
          next_snapshot_valid = 1'b0;
        end
      end
      ST_SETTLE: begin
        if (any_refresh) begin
          next_valid_count = VALID_CYCLES;
          next_snapshot_valid = 1'b0;
        end else if (valid_count <= COUNT_ONE) begin
          next_timer_state = ST_READY;
          next_valid_count = COUNT_ZERO;
          next_snapshot_valid = 1'b1;
        end else begin
          next_valid_count = valid_count - COUNT_ONE;
        end
      end
      default: begin
        next_timer_state = ST_READY;
        next_valid_count = COUNT_ZERO;
        next_snapshot_valid = 1'b1;
      end
    endcase
  end

  // Timer registers
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      timer_state <= ST_READY;
      valid_count <= COUNT_ZERO;
      snapshot_valid <= 1'b1;
    end else begin
      timer_state <= next_timer_state;
      valid_count <= next_valid_count;
      snapshot_valid <= next_snapshot_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux; reads alter no state
  always @* begin
    next_rdata = 8'h00;
    case (access_sel)
      SEL_PROG: begin
        next_rdata = prog_clean;
      end
      SEL_ACTIVE: begin
        next_rdata = active_clean;
      end
      SEL_LATCHED: begin
        next_rdata = latched_clean;
      end
      SEL_PRODUCT: begin
        next_rdata = `ID_PRODUCT_CODE;
      end
      SEL_MAKER: begin
        next_rdata = `ID_MAKER_CODE;
      end
      SEL_REVISION: begin
        next_rdata = `ID_DIE_REVISION_CODE;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Answer strobe, one cycle after the read strobe
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // Read data holds until the next read
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

//--- test/acc_chk_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module acc_chk(input wire clk_sys,rst_b,reg_rd,refresh,refresh_volt,refresh_general,
  reg_rvalid,snapshot_valid,input wire [7:0] reg_addr,reg_rdata,active_source);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire rf=refresh|refresh_volt|refresh_general;
  read_answer_a: assert property (reg_rd|=>reg_rvalid) else $error("no answer");
  snap_stale_a: assert property (rf|=>!snapshot_valid) else $error("valid");
  reset_state_a: assert property ($rose(rst_b)|->!active_source) else $error("rst");
  active_hold_a: assert property (!rf|=>$stable(active_source)) else $error("act");
  product_code_a: assert property (reg_rd&&reg_addr==8'hFD|=>reg_rdata==8'hA1) else $error("p");
  maker_code_a: assert property (reg_rd&&reg_addr==8'hFE|=>reg_rdata==8'hB2) else $error("m");
  revision_code_a: assert property (reg_rd&&reg_addr==8'hFF|=>reg_rdata==8'h01) else $error("r");
  no_reserved_a: assert property (reg_rd&&reg_addr[7:1]==7'h25
    |=>!(reg_rdata&reg_rdata>>1&8'h55)) else $error("code 3");
endmodule
bind accum_config_snapshot_and_id_regs acc_chk i_acc_chk(.*);
`default_nettype wire

//--- test/host.sv
`timescale 1ns/10ps
`default_nettype none
module host(input wire clk_sys,output logic reg_wr,reg_rd,output logic [7:0] reg_addr,
  reg_wdata,output logic [2:0] rf);
  logic [7:0] q[$];
  initial {reg_wr,reg_rd,reg_addr,reg_wdata,rf}<=0;
  task automatic op(input logic w,input logic [7:0] a,d);
    @(posedge clk_sys);
    {reg_wr,reg_rd,reg_addr,reg_wdata}<={w,!w,a,d};
    if(!w) q.push_back(d);
    @(posedge clk_sys);
    {reg_wr,reg_rd,reg_addr,reg_wdata}<={2'h0,~a,~d};
  endtask
  task automatic kick(input int k);
    @(posedge clk_sys);
    rf<=3'h1<<k;
    @(posedge clk_sys);
    rf<=0;
  endtask
endmodule
`default_nettype wire

//--- test/accum_config_snapshot_and_id_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module accum_config_snapshot_and_id_regs_tb_top;
  logic clk_sys=0,rst_b=0,reg_wr,reg_rd,reg_rvalid,snapshot_valid;
  logic [2:0] rf;
  logic [7:0] reg_addr,reg_wdata,reg_rdata,active_source,p,old,x;
  logic [7:0] a[6]='{8'h4B,8'h4A,8'hFD,8'hFE,8'hFF,8'h30},e[6]='{0,0,8'hA1,8'hB2,8'h01,0};
  int bad_count,check_count,cyc;
  initial forever #4 clk_sys=~clk_sys;
  host i_host(.clk_sys,.reg_wr,.reg_rd,.reg_addr,.reg_wdata,.rf);
  accum_config_snapshot_and_id_regs #(.VALID_CYCLES(10)) i_accum_config_snapshot_and_id_regs(
    .clk_sys,.rst_b,.reg_wr,.reg_rd,.reg_addr,.reg_wdata,.refresh(rf[0]),.refresh_volt(rf[1]),
    .refresh_general(rf[2]),.reg_rdata,.reg_rvalid,.active_source,.snapshot_valid);
  task chk(input logic [7:0] s,e);
    check_count++;
    if(s!==e) begin bad_count++; $display("wrong value %0t got %h want %h",$time,s,e); end
  endtask
  task results;
    $display("checks %0d errors %0d",check_count,bad_count);
    if(bad_count==0&&check_count>0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if(reg_rvalid===1'b1) chk(reg_rdata,i_host.q.pop_front());
    if(++cyc>500) begin bad_count++; results; end
  end
  initial begin
    void'($urandom(57848));
    repeat(2) @(posedge clk_sys);
    rst_b<=1;
    for(int i=0;i<6;i++) i_host.op(0,a[i],e[i]);
    i_host.op(1,8'hFD,8'h5A);
    i_host.op(0,8'hFD,8'hA1);
    old=0;
    for(int k=0;k<6;k++) begin
      p=8'($urandom);
      i_host.op(1,8'h25,p);
      i_host.kick(k%3);
      x=p&p>>1&8'h55;
      #1 chk(active_source,p);
      chk({7'h00,snapshot_valid},8'h00);
      repeat(9) @(posedge clk_sys);
      #1 chk({7'h00,snapshot_valid},8'h00);
      @(posedge clk_sys);
      #1 chk({7'h00,snapshot_valid},8'h01);
      wait(snapshot_valid===1'b1);
      i_host.op(0,8'h4B,old);
      old=p&~(x|x<<1);
      i_host.op(0,8'h4A,old);
    end
    repeat(3) @(posedge clk_sys);
    results;
  end
endmodule
`default_nettype wire
